// >>> core/dmz_fifo.v
// Read data FIFO built from flip-flops with valid and ready on both sides.
`timescale 1ns/100ps
module dmz_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock, reset and enable.
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Filling side.
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	// Draining side.
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);

	// Storage, pointers and registered fill flags.
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	reg full_q;
	reg empty_q;
	// Ready is kept in its own flop so the port comes straight from a register.
	reg ready_q;

	// Handshake terms for this cycle.
	wire push = in_valid_i & ~full_q;
	wire pop = out_ready_i & ~empty_q;
	wire [AW:0] count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	assign in_ready_o = ready_q;
	assign out_valid_o = ~empty_q;
	assign out_data_o = mem_q[rd_ptr_q];

	// Pointers wrap at the depth; flags are registered so ready comes from a flop.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			full_q <= 1'b0;
			empty_q <= 1'b1;
			ready_q <= 1'b1;
		end else if (ce_i) begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data_i;
				wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			full_q <= (count_d == DEPTH);
			ready_q <= (count_d != DEPTH);
			empty_q <= (count_d == {(AW+1){1'b0}});
		end
	end

endmodule

// >>> core/dmz_timing.v
// Device-side strobe framing, max power saving mode and calibration timing.
// How it works
// RL1 - Init calibration keeps device busy 1024 cycles.
// RL2 - Long calibration keeps device busy 512 cycles.
// RL3 - Short calibration keeps device busy 128 cycles.
// RL4 - Command path disabled after update plus disable delay.
// RL5 - Controller keeps clock valid after power-save entry.
// RL6 - Controller gives valid clock before power-save exit.
// RL7 - Controller waits exit delay before plain commands.
// RL8 - Controller waits extra lock delay for DLL commands.
// RL9 - Read preamble is one or two clocks.
// RL10 - Controller drives write preamble one or two clocks.
// RL11 - Read burst ends with half-clock low postamble.
// RL12 - Controller holds write postamble after write burst.
// RL13 - Read strobe driven from latency minus one; with pre_2t_i high the code drives it from latency minus two.
// RL14 - Read strobe released at latency plus half burst.
// RL15 - Exit delay is refresh cycle plus 10 ns.
// RL16 - Lock exit delay equals DLL locking time.
// RL17 - Update delay is max of 24 clocks, 15 ns.
// RL18 - Controller counts down each interval per rank.
`timescale 1ns/100ps
`include "dmz_timing_map.vh"
module dmz_timing #(
	parameter DQ_W = 8,
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW = 5,
	parameter RD_LAT = 11,
	parameter BURST_LEN = 8,
	parameter TMOD_NCK = 24,
	parameter TCPDED_NCK = 4
) (
	// Clock, reset and enable.
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Link from the controller, asynchronous to clk_i.
	input wire ck_i,
	input wire cke_i,
	input wire cs_n_i,
	input wire [2:0] cmd_i,
	// Mode select: high for the two-clock read preamble.
	input wire pre_2t_i,
	// Read data stream into the device.
	input wire [DQ_W-1:0] rd_data_i,
	input wire rd_valid_i,
	output wire rd_ready_o,
	// Strobe and data pins, output enable low while driving.
	output reg dqs_o,
	output reg dqs_oe_n_o,
	output reg [DQ_W-1:0] dq_o,
	output reg dq_oe_n_o,
	// Status.
	output reg zq_busy_o,
	output reg cmd_path_en_o,
	output reg mpsm_o
);

	// ======================================================================
	// Link input synchronisers.
	// ======================================================================
	localparam SW = 6;
	// Full-width sums, cut on purpose to the counter widths below.
	localparam MPED_SUM = TMOD_NCK + TCPDED_NCK;
	localparam RL_END_SUM = RD_LAT + BURST_LEN / 2;
	localparam [10:0] MPED_NCK = MPED_SUM[10:0];
	localparam [7:0] RL_START = RD_LAT[7:0];
	localparam [7:0] RL_END = RL_END_SUM[7:0];

	wire [SW-1:0] raw_in = {ck_i, cke_i, cs_n_i, cmd_i};
	reg [SW-1:0] sync1_q;
	reg [SW-1:0] sync2_q;
	reg [SW-1:0] sync3_q;
	reg [SW-1:0] filt_q;
	reg ck_prev_q;

	// Three flops per input; the first feeds only the second.
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= {SW{1'b0}};
			sync2_q <= {SW{1'b0}};
			sync3_q <= {SW{1'b0}};
		end else if (ce_i) begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// A bit changes only once the second and third stages agree.
	genvar gi;
	generate
		for (gi = 0; gi < SW; gi = gi + 1) begin : g_filt
			always @(posedge clk_i) begin
				if (rst_i) begin
					filt_q[gi] <= 1'b0;
				end else if (ce_i && (sync2_q[gi] == sync3_q[gi])) begin
					filt_q[gi] <= sync3_q[gi];
				end
			end
		end
	endgenerate

	// Filtered link signals and clock edges.
	wire ck_f = filt_q[5];
	wire cke_f = filt_q[4];
	wire cs_n_f = filt_q[3];
	wire [2:0] cmd_f = filt_q[2:0];
	wire ck_rise = ck_f & ~ck_prev_q;
	wire ck_fall = ~ck_f & ck_prev_q;

	// Tells whether a command of the given code is accepted now.
	function cmd_hit;
		input [2:0] code;
		input [2:0] cmd;
		input open;
		begin
			cmd_hit = open && (cmd == code);
		end
	endfunction

	// ======================================================================
	// Command acceptance and calibration and power-save timing.
	// ======================================================================
	localparam ST_RUN = 2'h0;
	localparam ST_MPED = 2'h1;
	localparam ST_MPSM = 2'h2;

	reg [1:0] state_q;
	reg [10:0] zq_cnt_q;
	reg [10:0] mp_cnt_q;
	reg zq_init_done_q;
	reg rd_act_q;

	// Commands are seen on a rising link edge with CS low and CKE high.
	wire cmd_open = ck_rise & ~cs_n_f & cke_f & cmd_path_en_o & ~zq_busy_o;
	wire take_rd = cmd_hit(`DMZ_CMD_READ, cmd_f, cmd_open) & ~rd_act_q;
	wire take_zql = cmd_hit(`DMZ_CMD_ZQ_LONG, cmd_f, cmd_open) & ~rd_act_q;
	wire take_zqs = cmd_hit(`DMZ_CMD_ZQ_SHORT, cmd_f, cmd_open) & ~rd_act_q;
	wire take_mp = cmd_hit(`DMZ_CMD_MPSM_ENTER, cmd_f, cmd_open) & (state_q == ST_RUN);

	// Calibration busy window; commands are ignored while it runs.
	always @(posedge clk_i) begin
		if (rst_i) begin
			zq_cnt_q <= `DMZ_COUNT_ZERO;
			zq_busy_o <= 1'b0;
			zq_init_done_q <= 1'b0;
		end else if (ce_i) begin
			if (take_zql && !zq_init_done_q) begin
				zq_cnt_q <= `DMZ_ZQ_INIT_NCK; // [RL1]
				zq_busy_o <= 1'b1;
				zq_init_done_q <= 1'b1;
			end else if (take_zql) begin
				zq_cnt_q <= `DMZ_ZQ_LONG_NCK; // [RL2]
				zq_busy_o <= 1'b1;
			end else if (take_zqs) begin
				zq_cnt_q <= `DMZ_ZQ_SHORT_NCK; // [RL3]
				zq_busy_o <= 1'b1;
			end else if (zq_busy_o && ck_rise) begin
				// Busy drops on the edge that ends the last cycle.
				zq_cnt_q <= zq_cnt_q - `DMZ_COUNT_ONE;
				zq_busy_o <= (zq_cnt_q != `DMZ_COUNT_ONE);
			end
		end
	end

	// Power-save entry disables the command path after the combined delay.
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_RUN;
			mp_cnt_q <= `DMZ_COUNT_ZERO;
			cmd_path_en_o <= 1'b1;
			mpsm_o <= 1'b0;
		end else if (ce_i) begin
			case (state_q)
				ST_RUN: begin
					if (take_mp) begin
						mp_cnt_q <= MPED_NCK; // [RL4]
						state_q <= ST_MPED;
					end
				end
				ST_MPED: begin
					// The controller keeps the clock running here. [RL5]
					if (ck_rise) begin
						mp_cnt_q <= mp_cnt_q - `DMZ_COUNT_ONE;
						if (mp_cnt_q == `DMZ_COUNT_ONE) begin
							cmd_path_en_o <= 1'b0; // [RL4]
							mpsm_o <= 1'b1;
							state_q <= ST_MPSM;
						end
					end
				end
				ST_MPSM: begin
					// Exit on a rising link clock edge with CKE high and CS low. [RL6]
					if (ck_rise && cke_f && !cs_n_f) begin
						cmd_path_en_o <= 1'b1;
						mpsm_o <= 1'b0;
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// ======================================================================
	// Read strobe framing.
	// ======================================================================
	reg [7:0] rd_cnt_q;
	reg post_q;

	// Lead of the preamble before the latency point.
	wire [7:0] lead = pre_2t_i ? `DMZ_PRE_2T_LEAD : `DMZ_PRE_1T_LEAD;
	wire in_burst = rd_act_q && !post_q && (rd_cnt_q >= RL_START) && (rd_cnt_q < RL_END);
	wire [7:0] cnt_next = rd_cnt_q + 8'h01;
	// A rise loads the word that goes out with it; a fall loads the next one.
	wire rise_beat = ck_rise && (cnt_next >= RL_START) && (cnt_next < RL_END);
	wire beat = rd_act_q && !post_q && (rise_beat || (ck_fall && in_burst));
	wire [DQ_W-1:0] fifo_data;
	wire fifo_valid;

	// Drives preamble, toggles through the burst, then postamble and release.
	always @(posedge clk_i) begin
		if (rst_i) begin
			rd_act_q <= 1'b0;
			post_q <= 1'b0;
			rd_cnt_q <= 8'h00;
			dqs_o <= 1'b0;
			dqs_oe_n_o <= 1'b1;
			dq_o <= {DQ_W{1'b0}};
			dq_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			if (take_rd) begin
				rd_act_q <= 1'b1;
				rd_cnt_q <= 8'h00;
			end else if (rd_act_q && ck_rise) begin
				rd_cnt_q <= cnt_next;
				if (cnt_next == RL_START - lead) begin
					dqs_oe_n_o <= 1'b0; // [RL13] [RL9]
					dqs_o <= 1'b0;
				end else if (cnt_next == RL_END) begin
					dqs_o <= 1'b0; // [RL11]
					dq_oe_n_o <= 1'b1;
					post_q <= 1'b1;
				end else if (cnt_next >= RL_START && cnt_next < RL_END) begin
					dqs_o <= 1'b1;
					dq_oe_n_o <= 1'b0;
				end
			end else if (rd_act_q && ck_fall) begin
				if (post_q) begin
					dqs_oe_n_o <= 1'b1; // [RL14]
					rd_act_q <= 1'b0;
					post_q <= 1'b0;
				end else if (in_burst) begin
					dqs_o <= 1'b0;
				end
			end
			// Each half clock of the burst takes the next word when one is there.
			if (beat && fifo_valid) begin
				dq_o <= fifo_data;
			end
		end
	end

	// ======================================================================
	// Read data buffer.
	// ======================================================================
	dmz_fifo #(
		.WIDTH(DQ_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_data_i(rd_data_i),
		.in_valid_i(rd_valid_i),
		.in_ready_o(rd_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(beat)
	);

	// Previous filtered link clock for edge finding.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ck_prev_q <= 1'b0;
		end else if (ce_i) begin
			ck_prev_q <= ck_f;
		end
	end

endmodule

// >>> core/dmz_timing_map.vh
// Named constants for the strobe, power-saving and calibration timing block.
`ifndef DMZ_TIMING_MAP_VH
`define DMZ_TIMING_MAP_VH

// ==========================================================================
// Command codes on cmd_i, taken at a rising link clock edge.
// ==========================================================================
`define DMZ_CMD_NOP 3'h0
`define DMZ_CMD_READ 3'h1
`define DMZ_CMD_ZQ_LONG 3'h2
`define DMZ_CMD_ZQ_SHORT 3'h3
`define DMZ_CMD_MPSM_ENTER 3'h4

// ==========================================================================
// Calibration durations in link clock cycles.
// ==========================================================================
`define DMZ_ZQ_INIT_NCK 11'h400
`define DMZ_ZQ_LONG_NCK 11'h200
`define DMZ_ZQ_SHORT_NCK 11'h080

// ==========================================================================
// Strobe framing leads and counter steps.
// ==========================================================================
`define DMZ_PRE_1T_LEAD 8'h01
`define DMZ_PRE_2T_LEAD 8'h02
`define DMZ_COUNT_ONE 11'h001
`define DMZ_COUNT_ZERO 11'h000

`endif

// >>> verif/dmz_ctrl_model.sv
// Controller model: free-running link clock and command issue.
`timescale 1ns/100ps
`include "dmz_timing_map.vh"
module dmz_ctrl_model (
	// Link toward the device.
	output logic ck_o,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] cmd_o
);
	// The link clock runs free so it stays valid around power save.
	initial begin
		ck_o = 1'b0;
		forever #62.5 ck_o = ~ck_o;
	end
	// Idle: enabled, deselected.
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		cmd_o = `DMZ_CMD_NOP;
	end
	// Issues one command at a link rise; pins change on falls only.
	task send(input logic [2:0] code);
		@(negedge ck_o);
		cs_n_o = 1'b0;
		cmd_o = code;
		@(negedge ck_o);
		cs_n_o = 1'b1;
		cmd_o = ~code;
	endtask
	// No write strobe is driven: write preamble and postamble stay with the controller.
	// Waits out an interval before the next command.
	task pause(input int n);
		repeat (n) @(negedge ck_o);
	endtask
endmodule

// >>> verif/dmz_timing_properties.sv
// Checker for strobe framing, calibration and power-save outputs.
`timescale 1ns/100ps
module dmz_timing_properties (
	// Clock and reset.
	input logic clk_i,
	input logic rst_i,
	// Watched outputs.
	input logic dqs_o,
	input logic dqs_oe_n_o,
	input logic dq_oe_n_o,
	input logic zq_busy_o,
	input logic cmd_path_en_o,
	input logic mpsm_o
);
	// ==========================================================
	// Helper logic
	// ==========================================================
	// Counts clock cycles of the current calibration.
	logic [15:0] busy_cnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !zq_busy_o) busy_cnt_q <= 16'h0000;
		else busy_cnt_q <= busy_cnt_q + 16'h0001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Sequences and assertions
	// ==========================================================
	// Strobe driven low with no data yet.
	sequence preamble_s;
		(!dqs_o && dq_oe_n_o) [*8];
	endsequence
	// Strobe still driven low after data ends.
	sequence postamble_s;
		(!dqs_o && !dqs_oe_n_o) [*4];
	endsequence
	pre_quiet_a: assert property ($fell(dqs_oe_n_o) |-> preamble_s)
		else $error("read preamble too short");
	data_strobe_a: assert property (!dq_oe_n_o |-> !dqs_oe_n_o)
		else $error("data driven without strobe");
	post_low_a: assert property ($rose(dq_oe_n_o) |-> postamble_s)
		else $error("read postamble too short");
	release_a: assert property ($rose(dqs_oe_n_o) |-> $past(dq_oe_n_o, 4) && !$past(dqs_o))
		else $error("strobe released early");
	// Short calibration lasts 1600 cycles, init 12800, jitter allowed.
	zq_min_a: assert property ($fell(zq_busy_o) |-> busy_cnt_q >= 16'h062c)
		else $error("calibration ended early");
	zq_max_a: assert property (zq_busy_o |-> busy_cnt_q <= 16'h321e)
		else $error("calibration ran too long");
	mpsm_flip_a: assert property (cmd_path_en_o != mpsm_o)
		else $error("path enable disagrees with power save");
	mpsm_quiet_a: assert property (mpsm_o |-> dqs_oe_n_o && dq_oe_n_o)
		else $error("pins driven in power save");
endmodule
bind dmz_timing dmz_timing_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .dqs_o(dqs_o),
	.dqs_oe_n_o(dqs_oe_n_o), .dq_oe_n_o(dq_oe_n_o), .zq_busy_o(zq_busy_o),
	.cmd_path_en_o(cmd_path_en_o), .mpsm_o(mpsm_o));

// >>> verif/dmz_timing_test.sv
// Self-checking bench for the timing block.
`timescale 1ns/100ps
`include "dmz_timing_map.vh"
module dmz_timing_test;
	localparam int RDL = 11;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pre_2t_i = 1'b0;
	logic [7:0] rd_data_i = 8'h00;
	logic rd_valid_i = 1'b0;
	logic ce_i = 1'b1;
	logic rdy;
	wire ck, cke, cs_n, rd_ready_o, dqs_o, dqs_oe_n_o, dq_oe_n_o, zq_busy_o, cmd_path_en_o, mpsm_o;
	wire [2:0] cmd;
	wire [7:0] dq_o;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	int i;
	int r;
	dmz_timing i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ck_i(ck), .cke_i(cke),
		.cs_n_i(cs_n), .cmd_i(cmd), .pre_2t_i(pre_2t_i), .rd_data_i(rd_data_i),
		.rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o),
		.dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .zq_busy_o(zq_busy_o),
		.cmd_path_en_o(cmd_path_en_o), .mpsm_o(mpsm_o));
	dmz_ctrl_model i_ctl (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd));
	// 100 MHz clock.
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Cuts a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			conclude;
		end
	end
	// Compares one value and counts.
	task check(input logic [15:0] seen, input logic [15:0] want, input string what);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	// Prints counts and the verdict.
	task conclude;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Counts link cycles of one calibration.
	task zq_run(input logic [2:0] code, input int want);
		i_ctl.send(code);
		check(zq_busy_o, 1, "busy start");
		n = 0;
		while (zq_busy_o === 1'b1 && n < 2000) begin
			@(negedge ck);
			n++;
		end
		check(n, want, "busy length");
	endtask
	// Offers words with the enable low; the frozen buffer must take none.
	task freeze;
		@(posedge clk_i);
		#1 ce_i = 1'b0;
		rd_valid_i = 1'b1;
		repeat (40) @(posedge clk_i);
		#1 rd_valid_i = 1'b0;
		check(rd_ready_o, 1, "frozen buffer");
		ce_i = 1'b1;
	endtask
	// Pushes words until the buffer refuses.
	task fill;
		n = 0;
		@(posedge clk_i);
		#1 rd_valid_i = 1'b1;
		rd_data_i = 8'ha0;
		repeat (40) begin
			@(negedge clk_i) rdy = rd_ready_o;
			@(posedge clk_i);
			if (rdy === 1'b1) n++;
			#1 rd_data_i = 8'ha0 + n[7:0];
		end
		rd_valid_i = 1'b0;
		check(n, 32, "buffer depth");
		check(rd_ready_o, 0, "buffer full");
	endtask
	// One read burst, strobe framing and eight words.
	task read_burst(input logic two, input logic [7:0] base);
		@(posedge clk_i);
		#1 pre_2t_i = two;
		i_ctl.send(`DMZ_CMD_READ);
		n = 0;
		while (dqs_oe_n_o === 1'b1 && n < 20) begin
			@(negedge ck);
			n++;
		end
		check(n, RDL - 1 - two, "strobe start");
		check(dqs_o, 0, "preamble level");
		if (two) @(negedge ck);
		@(negedge ck);
		for (i = 0; i < 8; i++) begin
			if (i > 0) @(ck);
			check(dq_o, base + i[7:0], "burst word");
			check({dqs_o, dq_oe_n_o}, {!i[0], 1'b0}, "burst strobe");
		end
		@(negedge ck);
		check({dqs_o, dq_oe_n_o, dqs_oe_n_o}, 3'b010, "postamble");
		@(posedge ck);
		check(dqs_oe_n_o, 1, "strobe release");
	endtask
	// Enters power save, then a select exits and the command is refused.
	task mpsm;
		i_ctl.send(`DMZ_CMD_MPSM_ENTER);
		n = 0;
		while (cmd_path_en_o === 1'b1 && n < 40) begin
			@(negedge ck);
			n++;
		end
		check(n, 28, "path disable delay");
		check(mpsm_o, 1, "power save on");
		i_ctl.send(`DMZ_CMD_ZQ_SHORT);
		check({mpsm_o, cmd_path_en_o, zq_busy_o}, 3'b010, "power save exit");
		i_ctl.pause(16);
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		#1 rst_i = 1'b0;
		check({dqs_o, dqs_oe_n_o, dq_oe_n_o, zq_busy_o, cmd_path_en_o, mpsm_o, rd_ready_o},
			16'h0035, "reset values");
		repeat (10) @(posedge clk_i);
		zq_run(`DMZ_CMD_ZQ_LONG, 1024);
		zq_run(`DMZ_CMD_ZQ_LONG, 512);
		zq_run(`DMZ_CMD_ZQ_SHORT, 128);
		freeze;
		fill;
		for (r = 0; r < 4; r++) begin
			read_burst(r[0], 8'ha0 + 8 * r[7:0]);
		end
		check(rd_ready_o, 1, "buffer drained");
		mpsm;
		conclude;
	end
endmodule
